// File: arr_defines.svh
// register offsets, field positions, reset values and timing counts of
// the auto-restart controller; assumes a 40 MHz system clock
`ifndef ARR_DEFINES_SVH
`define ARR_DEFINES_SVH

// byte offsets on the register bus
`define ARR_ADDR_W 5
`define ARR_OFF_CFG 5'h00
`define ARR_OFF_DELAY 5'h04
`define ARR_OFF_CURLIM 5'h08
`define ARR_OFF_STATUS 5'h0C
`define ARR_OFF_IRQ_STAT 5'h10
`define ARR_OFF_IRQ_MASK 5'h14
`define ARR_OFF_CMD 5'h18

// field positions
`define ARR_CFG_TRY_LSB 0
`define ARR_CFG_SS_LSB 8
`define ARR_ST_REMAIN_LSB 0
`define ARR_ST_STATE_LSB 4
`define ARR_ST_LOCK_BIT 8
`define ARR_CMD_RESET_BIT 0
`define ARR_IRQ_TRIP 0
`define ARR_IRQ_RESTART 1
`define ARR_IRQ_LOCK 2
`define ARR_IRQ_RESTORE 3

// limits and reset values (delay counted in 0.1 s steps)
`define ARR_TRY_RST 10'h000
`define ARR_TRY_MAX 10'h00A
`define ARR_DELAY_RST 10'h00A
`define ARR_DELAY_MAX 10'h258
`define ARR_CUR_RST 10'h064
`define ARR_CUR_MIN 10'h050
`define ARR_CUR_MAX 10'h0C8
`define ARR_SS_RST 4'h0
`define ARR_ZERO 10'h000

// timing
`define ARR_CLK_HZ 40000000
`define ARR_TICK_MS 100
`define ARR_TICK_CYCLES (`ARR_CLK_HZ / 1000 * `ARR_TICK_MS)
`define ARR_WATCH_S 30
`define ARR_WATCH_TICKS (`ARR_WATCH_S * 1000 / `ARR_TICK_MS)

`endif

// File: arr_pkg.sv
// types of the auto-restart controller
// assumes arr_defines.svh is reachable by bare name
package arr_pkg;
  `include "arr_defines.svh"

  typedef enum logic [2:0]
  {
    ARR_IDLE = 3'h0,
    ARR_WAIT = 3'h1,
    ARR_SEARCH = 3'h3,
    ARR_WATCH = 3'h2,
    ARR_LOCK = 3'h6
  } arr_state_t;

  typedef struct packed
  {
    arr_state_t st;
    logic [3:0] remain;
    logic [3:0] max_try;
    logic [9:0] delay;
    logic [7:0] cur_lim;
    logic [3:0] ss_sel;
    logic [9:0] tcnt;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic aw_got;
    logic w_got;
    logic [`ARR_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic restart;
  } arr_regs_t;

  typedef struct packed
  {
    logic [31:0] cnt;
    logic tick;
  } arr_tick_regs_t;
endpackage

// File: arr_tick.sv
// 0.1 s timebase: one-cycle tick every CYCLES clocks
// assumes the system clock and synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module arr_tick
#(
  parameter int unsigned CYCLES = 4000000
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // timebase
  output logic tick
);
  import arr_pkg::*;

  arr_tick_regs_t s_reg;
  arr_tick_regs_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= 32'(CYCLES - 1))
    begin
      s_next.cnt = 32'h0;
      s_next.tick = 1'b1;
    end
    else
      s_next.cnt = s_reg.cnt + 32'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tick = s_reg.tick;
endmodule // arr_tick
`default_nettype wire

// File: arr_ctrl.sv
// auto-restart controller: trip handling, restart delay, try counter,
// speed-search launch, AXI4-Lite registers and interrupt
// assumes trip inputs are synchronous one-cycle pulses with cause levels
// valid in the same cycle
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "arr_defines.svh"
module arr_ctrl
#(
  parameter int unsigned TICK_CYCLES = `ARR_TICK_CYCLES
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [`ARR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`ARR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trip protection side
  input wire logic trip,
  input wire logic trip_undervolt,
  input wire logic emergency_stop_trip,
  input wire logic fault_reset_term,
  // speed search side
  input wire logic search_done,
  output logic restart_start,
  output logic search_active,
  output logic [7:0] search_current_limit,
  output logic [3:0] speed_search_select,
  // status
  output logic restart_pending,
  output logic drive_inhibit,
  output logic [3:0] restart_try_count,
  output logic irq
);
  import arr_pkg::*;
  arr_regs_t s_reg;
  arr_regs_t s_next;
  logic tick;
  function automatic logic [9:0] arr_clamp(input logic [9:0] v,
    input logic [9:0] lo, input logic [9:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    return v;
  endfunction
  function automatic logic [31:0] arr_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction
  arr_tick #(.CYCLES(TICK_CYCLES)) u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );
  logic do_wr;
  logic wr_ok;
  logic fault_any;
  logic [31:0] wv;
  logic [31:0] rd;
  logic rd_ok;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic [9:0] tmp;
  logic [`ARR_ADDR_W-1:0] wa;
  logic [`ARR_ADDR_W-1:0] ra;
  always_comb
  begin
    s_next = s_reg;
    irq_set = 4'h0;
    irq_clr = 4'h0;
    fault_any = fault_reset_term;
    s_next.restart = 1'b0;
    wa = {s_reg.awaddr[`ARR_ADDR_W-1:2], 2'b00};
    ra = {s_axi_araddr[`ARR_ADDR_W-1:2], 2'b00};
    wv = 32'h0;
    tmp = 10'h000;
    rd = 32'h0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    do_wr = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    if (s_axi_bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (do_wr)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      if (wa == `ARR_OFF_CFG)
      begin
        wv = arr_merge({20'h0, s_reg.ss_sel, 4'h0, s_reg.max_try},
          s_reg.wdata, s_reg.wstrb);
        tmp = arr_clamp({6'h0, wv[`ARR_CFG_TRY_LSB +: 4]},
          `ARR_ZERO, `ARR_TRY_MAX);
        s_next.max_try = tmp[3:0];
        s_next.ss_sel = wv[`ARR_CFG_SS_LSB +: 4];
      end
      else if (wa == `ARR_OFF_DELAY)
      begin
        wv = arr_merge({22'h0, s_reg.delay}, s_reg.wdata, s_reg.wstrb);
        s_next.delay = arr_clamp(wv[9:0], `ARR_ZERO, `ARR_DELAY_MAX);
      end
      else if (wa == `ARR_OFF_CURLIM)
      begin
        wv = arr_merge({24'h0, s_reg.cur_lim}, s_reg.wdata, s_reg.wstrb);
        tmp = arr_clamp({2'h0, wv[7:0]}, `ARR_CUR_MIN, `ARR_CUR_MAX);
        s_next.cur_lim = tmp[7:0];
      end
      else if (wa == `ARR_OFF_IRQ_STAT)
      begin
        if (s_reg.wstrb[0])
          irq_clr = s_reg.wdata[3:0];
      end
      else if (wa == `ARR_OFF_IRQ_MASK)
      begin
        if (s_reg.wstrb[0])
          s_next.irq_mask = s_reg.wdata[3:0];
      end
      else if (wa == `ARR_OFF_CMD)
      begin
        if (s_reg.wstrb[0] && s_reg.wdata[`ARR_CMD_RESET_BIT])
          fault_any = 1'b1;
      end
      else if (wa != `ARR_OFF_STATUS)
        wr_ok = 1'b0;
      s_next.bresp = wr_ok ? 2'b00 : 2'b10;
    end
    // read channel
    if (s_axi_rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      if (ra == `ARR_OFF_CFG)
        rd = {20'h0, s_reg.ss_sel, 4'h0, s_reg.max_try};
      else if (ra == `ARR_OFF_DELAY)
        rd = {22'h0, s_reg.delay};
      else if (ra == `ARR_OFF_CURLIM)
        rd = {24'h0, s_reg.cur_lim};
      else if (ra == `ARR_OFF_STATUS)
        rd = {23'h0, s_reg.st == ARR_LOCK, 1'b0, s_reg.st, s_reg.remain};
      else if (ra == `ARR_OFF_IRQ_STAT)
        rd = {28'h0, s_reg.irq_stat};
      else if (ra == `ARR_OFF_IRQ_MASK)
        rd = {28'h0, s_reg.irq_mask};
      else if (ra != `ARR_OFF_CMD)
        rd_ok = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd;
      s_next.rresp = rd_ok ? 2'b00 : 2'b10;
    end
    // restart sequencer
    if (tick && s_reg.st inside {ARR_WAIT, ARR_WATCH})
      s_next.tcnt = s_reg.tcnt + 10'h001;
    case (s_reg.st)
      ARR_WAIT:
      begin
        if (s_reg.remain == 4'h0)
          s_next.st = ARR_LOCK;
        else if (s_reg.tcnt >= s_reg.delay)
        begin
          s_next.st = ARR_SEARCH;
          s_next.restart = 1'b1;
          s_next.remain = s_reg.remain - 4'h1;
          irq_set[`ARR_IRQ_RESTART] = 1'b1;
        end
      end
      ARR_SEARCH:
      begin
        if (search_done)
        begin
          s_next.st = ARR_WATCH;
          s_next.tcnt = 10'h000;
        end
      end
      ARR_WATCH:
      begin
        if (s_reg.tcnt >= 10'(`ARR_WATCH_TICKS))
        begin
          s_next.st = ARR_IDLE;
          s_next.remain = s_reg.max_try;
          irq_set[`ARR_IRQ_RESTORE] = 1'b1;
        end
      end
      ARR_LOCK:
      begin
        if (fault_any)
          s_next.st = ARR_IDLE;
      end
      default:
      begin
        s_next.st = ARR_IDLE;
      end
    endcase
    if (trip && s_reg.st != ARR_WAIT && s_reg.st != ARR_LOCK)
    begin
      irq_set[`ARR_IRQ_TRIP] = 1'b1;
      s_next.tcnt = 10'h000;
      s_next.remain = s_reg.remain;
      if (trip_undervolt || emergency_stop_trip || s_reg.remain == 4'h0)
      begin
        s_next.st = ARR_LOCK;
        irq_set[`ARR_IRQ_LOCK] = 1'b1;
      end
      else
        s_next.st = ARR_WAIT;
    end
    if (fault_any)
      s_next.remain = s_reg.max_try;
    // set wins over clear
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_set;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.st <= ARR_IDLE;
      s_reg.remain <= 4'(`ARR_TRY_RST);
      s_reg.max_try <= 4'(`ARR_TRY_RST);
      s_reg.delay <= `ARR_DELAY_RST;
      s_reg.cur_lim <= 8'(`ARR_CUR_RST);
      s_reg.ss_sel <= `ARR_SS_RST;
    end
    else
      s_reg <= s_next;
  end
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign restart_start = s_reg.restart;
  assign search_active = s_reg.st == ARR_SEARCH;
  assign search_current_limit = s_reg.cur_lim;
  assign speed_search_select = s_reg.ss_sel;
  assign restart_pending = s_reg.st == ARR_WAIT;
  assign drive_inhibit = s_reg.st == ARR_LOCK;
  assign restart_try_count = s_reg.remain;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence restart_go;
    restart_start;
  endsequence
  sequence watch_done;
    s_reg.st == ARR_WATCH && s_reg.tcnt >= 10'(`ARR_WATCH_TICKS)
      && !trip && !fault_any;
  endsequence
  sequence free_trip;
    trip && s_reg.st inside {ARR_IDLE, ARR_SEARCH, ARR_WATCH}
      && !fault_any;
  endsequence
  try_range_a: assert property (s_reg.max_try <= 4'hA)
    else $error("maximum try count above ten");
  delay_wait_a: assert property (restart_go |->
    $past(s_reg.tcnt) >= $past(s_reg.delay))
    else $error("restart before the delay elapsed");
  try_decrement_a: assert property (restart_go and !$past(fault_any) |->
    s_reg.remain == $past(s_reg.remain) - 4'h1)
    else $error("remaining tries not lowered by one");
  no_tries_lock_a: assert property (free_trip and s_reg.remain == 4'h0
    |=> drive_inhibit ##1 !restart_start)
    else $error("trip with no tries left did not lock");
  reset_reload_a: assert property (fault_any |=>
    s_reg.remain == $past(s_reg.max_try))
    else $error("fault reset did not reload the tries");
  watch_restore_a: assert property (watch_done |=>
    s_reg.remain == $past(s_reg.max_try) && s_reg.st == ARR_IDLE)
    else $error("tries not restored after quiet interval");
  uv_estop_lock_a: assert property (free_trip and
    (trip_undervolt || emergency_stop_trip) |=> drive_inhibit)
    else $error("undervoltage or emergency trip not locked");
  search_launch_a: assert property (restart_go |->
    search_active && $past(restart_pending))
    else $error("restart did not enter speed search");
  cur_limit_a: assert property (search_active |->
    search_current_limit >= 8'h50 && search_current_limit <= 8'hC8)
    else $error("search current limit out of range");
  zero_max_a: assert property (s_reg.max_try == 4'h0 &&
    s_reg.remain == 4'h0 && !restart_pending |=> !restart_start)
    else $error("restart with zero maximum tries");
  irq_level_a: assert property (irq == |(s_reg.irq_stat & s_reg.irq_mask))
    else $error("interrupt output mismatch");
endmodule // arr_ctrl
`default_nettype wire

// File: arr_search_model.sv
// speed-search model: answers each restart launch with a done pulse
// assumes the system clock, synchronous active-low reset, lat from bench
`timescale 1ns/10ps
`default_nettype none
module arr_search_model
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controller side
  input wire logic restart_start,
  input wire logic [7:0] lat,
  output logic search_done
);
  logic [7:0] cnt;
  logic busy;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      search_done <= 1'b0;
    end
    else
    begin
      search_done <= 1'b0;
      // a search runs only after a launch, for lat+1 cycles
      if (restart_start)
      begin
        busy <= 1'b1;
        cnt <= lat;
      end
      else if (busy && cnt == 8'h00)
      begin
        busy <= 1'b0;
        search_done <= 1'b1;
      end
      else if (busy)
        cnt <= cnt - 8'h01;
    end
  end
endmodule // arr_search_model
`default_nettype wire

// File: auto_restart_retry_control_bench.sv
// bench of the auto-restart controller: registers, trips, tries, irq
// assumes arr_pkg, arr_ctrl and arr_search_model compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "arr_defines.svh"
module auto_restart_retry_control_bench;
  import arr_pkg::*;
  logic aclk, aresetn;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, tries, ss_sel;
  logic [1:0] bresp, rresp, resp;
  logic trip, uv, estop, freset, sdone, rstart, sact, pend, inh, irq;
  logic [7:0] curlim, lat;
  int errors, n_checks, cyc, n;

  arr_ctrl #(.TICK_CYCLES(4)) i_arr_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trip(trip),
    .trip_undervolt(uv), .emergency_stop_trip(estop),
    .fault_reset_term(freset), .search_done(sdone), .restart_start(rstart),
    .search_active(sact), .search_current_limit(curlim),
    .speed_search_select(ss_sel), .restart_pending(pend),
    .drive_inhibit(inh), .restart_try_count(tries), .irq(irq));
  arr_search_model i_arr_search_model (.aclk(aclk), .aresetn(aresetn),
    .restart_start(rstart), .lat(lat), .search_done(sdone));

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end
    while (!rvalid);
    resp = rresp;
    chk(rdata, e);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pulse(input logic t, input logic u, input logic e,
                       input logic f);
    trip <= t;
    uv <= u;
    estop <= e;
    freset <= f;
    @(posedge aclk);
    trip <= 1'b0;
    uv <= 1'b0;
    estop <= 1'b0;
    freset <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_start();
    n = 0;
    while (!rstart)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic t_reset();
    rchk(`ARR_OFF_CFG, 32'h0);
    rchk(`ARR_OFF_DELAY, 32'h0000000A);
    rchk(`ARR_OFF_CURLIM, 32'h00000064);
    rchk(5'h1C, 32'h0);
    chk(resp, 2'h2);
    wr(5'h1C, 32'hFFFFFFFF);
    chk(resp, 2'h2);
  endtask

  task automatic t_zero();
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk(inh, 1'b1);
    chk(pend, 1'b0);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    chk(inh, 1'b0);
  endtask

  task automatic t_cfg();
    wr(`ARR_OFF_CFG, 32'h0000070F);
    rchk(`ARR_OFF_CFG, 32'h0000070A);
    chk(ss_sel, 4'h7);
    wr(`ARR_OFF_DELAY, 32'h000003FF);
    rchk(`ARR_OFF_DELAY, 32'h00000258);
    wr(`ARR_OFF_CURLIM, 32'h00000010);
    rchk(`ARR_OFF_CURLIM, 32'h00000050);
    wr(`ARR_OFF_CURLIM, 32'h000000FF);
    chk(curlim, 8'hC8);
  endtask

  task automatic t_run();
    wr(`ARR_OFF_CFG, 32'h00000002);
    wr(`ARR_OFF_DELAY, 32'h00000003);
    wr(`ARR_OFF_CMD, 32'h00000001);
    chk(tries, 4'h2);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk(pend, 1'b1);
    wait_start();
    chk(n >= 8 && n <= 16, 1'b1);
    chk(tries, 4'h1);
    chk(sact, 1'b1);
    repeat (12) @(posedge aclk);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    wait_start();
    chk(tries, 4'h0);
    repeat (12) @(posedge aclk);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk(inh, 1'b1);
    chk(irq, 1'b0);
    wr(`ARR_OFF_IRQ_MASK, 32'h00000004);
    chk(irq, 1'b1);
    rchk(`ARR_OFF_STATUS, 32'h00000160);
    wr(`ARR_OFF_IRQ_STAT, 32'h00000004);
    chk(irq, 1'b0);
    rchk(`ARR_OFF_IRQ_STAT, 32'h00000003);
  endtask

  task automatic t_restore();
    wr(`ARR_OFF_DELAY, 32'h00000000);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    chk(tries, 4'h2);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    wait_start();
    chk(tries, 4'h1);
    repeat (1100) @(posedge aclk);
    chk(tries, 4'h1);
    n = 0;
    while (tries !== 4'h2 && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    chk(tries, 4'h2);
    rchk(`ARR_OFF_IRQ_STAT, 32'h0000000B);
  endtask

  task automatic t_inhibit();
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    chk(inh, 1'b1);
    chk(tries, 4'h2);
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    pulse(1'b1, 1'b0, 1'b1, 1'b0);
    chk(inh, 1'b1);
    chk(pend, 1'b0);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {trip, uv, estop, freset} = '0;
    wstrb = 4'hF;
    lat = 8'h05;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_zero();
    t_cfg();
    t_run();
    t_restore();
    t_inhibit();
    give_verdict();
  end
endmodule // auto_restart_retry_control_bench
`default_nettype wire
